// ===== verilog/ipsc_map.vh
// register map, field positions and reset values of the priority and sense controller
`ifndef IPSC_MAP_VH
`define IPSC_MAP_VH
// register word indices, byte address is four times the index
`define IPSC_IDX_PRIO_FIRST 4'h0
`define IPSC_IDX_PRIO_LAST 4'h7
`define IPSC_IDX_SENSE 4'h8
`define IPSC_IDX_FLAGS 4'h9
// reset values
`define IPSC_PRIO_RST 16'h0000
`define IPSC_NMI_EDGE_SELECT_RST 1'b0
`define IPSC_SENSE_RST 8'h00
`define IPSC_FLAGS_RST 8'h00
// field positions of the sense control register
`define IPSC_NMI_PIN_LEVEL_BIT 15
`define IPSC_NMI_EDGE_SELECT_BIT 8
// width of one level field
`define IPSC_FIELD_W 4
`endif

// ===== verilog/ipsc_top.v
// interrupt priority, input sense and request selection with an apb register slave
//
// Operation
// RQ1: each 4-bit level field gives level 0 (code 0) up to 15 (code f).
// RQ2: every priority register holds four fields at 15-12, 11-8, 7-4, 3-0.
// RQ3: watchdog and bus sources sharing a field both take that field's level.
// RQ4: priority registers clear on power-on and manual reset, kept otherwise.
// RQ5: sense register bit 15 reads the nmi pin level, writes ignored.
// RQ6: reserved bits read zero; software writes only zero to them.
// RQ7: sense register bit 8 picks nmi edge: 0 falling, 1 rising.
// RQ8: sense bits 7-0 pick pin mode, bit 7 pin 0: 0 low level, 1 falling edge.
// RQ9: sense register is set by power-on reset only.
// RQ10: flag bits 7-0 show request of pins 0-7, bit 7 for pin 0.
// RQ11: edge request cancelled by writing 0 to its flag after reading 1.
// RQ12: level-mode flag reads 0 while the pin is high.
// RQ13: flag register clears on power-on reset, kept otherwise.
// RQ14: each peripheral source carries a fixed vector number.
// RQ15: sources sharing one field are ranked in a fixed order.
// RQ16: a-mask variant has converter sources 136 and 137 on register g top field.
// RQ17: flag sets while pin low in level mode, on falling edge in edge mode.
// RQ18: edge flag also clears on its exception processing or transfer end.
// RQ19: request goes to cpu only if its level is above the cpu mask.
// RQ20: writing 1, or 0 without a prior read of 1, leaves a flag alone.
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "ipsc_map.vh"

module ipsc_top #(
   parameter AMASK = 0
)(
   // clock and resets
   input wire clk_i,
   input wire resetn_i,
   input wire manual_reset_i,
   // apb slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire [3:0] pstrb_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o,
   // external pins
   input wire nmi_pin_i,
   input wire [7:0] external_request_pins_n_i,
   // peripheral request levels
   input wire [42:0] periph_req_i,
   // cpu side
   input wire [3:0] cpu_mask_level_i,
   input wire [7:0] pin_accept_i,
   input wire [7:0] xfer_done_i,
   output reg irq_req_o,
   output reg [7:0] irq_vector_o,
   output reg [3:0] irq_level_o,
   output reg request_pending_output_n_o,
   output reg nmi_detect_o
);

   localparam NSRC = 51;

   // source table: {field index, vector}, order gives the fixed ranking
   function [12:0] ipsc_src;
      input [5:0] s;
      begin
         case (s)
            6'd0: ipsc_src = {5'h08, 8'h48};
            6'd1: ipsc_src = {5'h09, 8'h4c};
            6'd2: ipsc_src = {5'h0a, 8'h50};
            6'd3: ipsc_src = {5'h0b, 8'h54};
            6'd4: ipsc_src = {5'h0c, 8'h58};
            6'd5: ipsc_src = {5'h0c, 8'h59};
            6'd6: ipsc_src = {5'h0c, 8'h5a};
            6'd7: ipsc_src = {5'h0c, 8'h5b};
            6'd8: ipsc_src = {5'h0d, 8'h5c};
            6'd9: ipsc_src = {5'h0e, 8'h60};
            6'd10: ipsc_src = {5'h0e, 8'h61};
            6'd11: ipsc_src = {5'h0f, 8'h64};
            6'd12: ipsc_src = {5'h0f, 8'h65};
            6'd13: ipsc_src = {5'h10, 8'h68};
            6'd14: ipsc_src = {5'h10, 8'h69};
            6'd15: ipsc_src = {5'h11, 8'h6c};
            6'd16: ipsc_src = {5'h11, 8'h6d};
            6'd17: ipsc_src = {5'h12, 8'h70}; // timer 3 compare a
            6'd18: ipsc_src = {5'h12, 8'h71};
            6'd19: ipsc_src = {5'h12, 8'h72};
            6'd20: ipsc_src = {5'h12, 8'h73};
            6'd21: ipsc_src = {5'h13, 8'h74};
            6'd22: ipsc_src = {5'h14, 8'h78};
            6'd23: ipsc_src = {5'h14, 8'h79};
            6'd24: ipsc_src = {5'h14, 8'h7a};
            6'd25: ipsc_src = {5'h14, 8'h7b};
            6'd26: ipsc_src = {5'h15, 8'h7c};
            6'd27: ipsc_src = {5'h16, 8'h80}; // serial 0 error
            6'd28: ipsc_src = {5'h16, 8'h81}; // serial 0 receive full
            6'd29: ipsc_src = {5'h16, 8'h82}; // serial 0 transmit empty
            6'd30: ipsc_src = {5'h16, 8'h83}; // serial 0 transmit end
            6'd31: ipsc_src = {5'h17, 8'h84};
            6'd32: ipsc_src = {5'h17, 8'h85};
            6'd33: ipsc_src = {5'h17, 8'h86};
            6'd34: ipsc_src = {5'h17, 8'h87};
            6'd35: ipsc_src = {5'h18, 8'h88}; // converter end 0
            6'd36: ipsc_src = {5'h18, 8'h89}; // converter end 1, a-mask only
            6'd37: ipsc_src = {5'h19, 8'h8c};
            6'd38: ipsc_src = {5'h1a, 8'h90};
            6'd39: ipsc_src = {5'h1b, 8'h94};
            6'd40: ipsc_src = {5'h1c, 8'h98}; // watchdog
            6'd41: ipsc_src = {5'h1c, 8'h99}; // bus controller, same field
            6'd42: ipsc_src = {5'h1d, 8'h9c}; // port output enable
            default: ipsc_src = 13'h0000;
         endcase
      end
   endfunction

   // input synchronisers, bit 8 is the nmi pin
   reg [8:0] sync_a;
   reg [8:0] sync_b;
   reg [8:0] pin_prev;

   // register state
   reg [15:0] prio [0:7];
   reg nmi_edge_select;
   reg [7:0] pin_sense_select; // indexed by pin number
   reg [7:0] edge_flag; // indexed by pin number
   reg [7:0] armed; // flag read as 1, clear may follow

   // arbiter combinational results
   reg [3:0] best_lvl;
   reg [7:0] best_vec;
   reg [3:0] lvl;
   reg [12:0] ent;
   reg [50:0] req_all;
   integer s;
   integer k;
   integer kf; // loop index of the held request process
   integer ka; // loop index of the arming process

   // bus decode
   wire [3:0] idx = paddr_i[5:2];
   wire mapped = (paddr_i[11:6] == 6'h00) && (idx <= `IPSC_IDX_FLAGS);
   wire setup = psel_i & ~penable_i;
   wire done = psel_i & penable_i & pready_o;
   wire wr = done & pwrite_i & ~pslverr_o;
   wire rd = done & ~pwrite_i & ~pslverr_o;
   wire [15:0] bmask = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
   wire wr_prio = wr && (idx <= `IPSC_IDX_PRIO_LAST);
   wire wr_sense = wr && (idx == `IPSC_IDX_SENSE);
   // flags live in the low byte, so a flag write needs that lane
   wire wr_flags = wr && (idx == `IPSC_IDX_FLAGS) && pstrb_i[0];
   wire rd_flags = rd && (idx == `IPSC_IDX_FLAGS);

   // per-pin derived signals
   wire [7:0] pin_low = ~sync_b[7:0];
   wire [7:0] pin_fall = pin_prev[7:0] & ~sync_b[7:0];
   wire [7:0] shown; // indexed by pin number
   wire [7:0] shown_rev; // bit 7 is pin 0
   wire [7:0] sense_rev;
   wire [7:0] wdata_rev;
   wire [7:0] clr_req;

   genvar n;
   generate
      for (n = 0; n < 8; n = n + 1)
      begin : g_pin
         // level mode follows the pin, edge mode the held request
         assign shown[n] = pin_sense_select[n] ? edge_flag[n] : pin_low[n]; // see RQ12 see RQ17
         assign shown_rev[7-n] = shown[n]; // see RQ10
         assign sense_rev[7-n] = pin_sense_select[n];
         assign wdata_rev[n] = pwdata_i[7-n];
         // software clear only after a read of 1, and only with a 0 written
         assign clr_req[n] = (wr_flags & ~wdata_rev[n] & armed[n]) // see RQ11 see RQ20
            | pin_accept_i[n] | xfer_done_i[n]; // see RQ18
      end
   endgenerate

   // two-stage synchronisers and edge history
   // reset to the idle-high level so that release of reset shows no false edge
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         sync_a <= 9'h1ff;
         sync_b <= 9'h1ff;
         pin_prev <= 9'h1ff;
      end
      else
      begin
         sync_a <= {nmi_pin_i, external_request_pins_n_i};
         sync_b <= sync_a;
         pin_prev <= sync_b;
      end
   end

   // priority registers, byte lanes honoured
   // manual reset clears only these registers; sense and flags are kept
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         for (k = 0; k < 8; k = k + 1)
            prio[k] <= `IPSC_PRIO_RST; // see RQ4
      end
      else if (manual_reset_i)
      begin
         for (k = 0; k < 8; k = k + 1)
            prio[k] <= `IPSC_PRIO_RST; // see RQ4
      end
      else if (wr_prio)
      begin
         prio[idx[2:0]] <= (prio[idx[2:0]] & ~bmask) | (pwdata_i[15:0] & bmask); // see RQ2
      end
   end

   // sense control register, power-on reset only
   // the nmi level bit is never stored, it reads the synchronised pin
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         nmi_edge_select <= `IPSC_NMI_EDGE_SELECT_RST; // see RQ9
         pin_sense_select <= `IPSC_SENSE_RST;
      end
      else if (wr_sense)
      begin
         if (pstrb_i[1])
            nmi_edge_select <= pwdata_i[`IPSC_NMI_EDGE_SELECT_BIT]; // see RQ7
         if (pstrb_i[0])
            pin_sense_select <= wdata_rev; // see RQ8
      end
   end

   // held edge requests: a new edge wins over any clear in the same cycle
   // switching a pin to level mode drops its held request
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         edge_flag <= `IPSC_FLAGS_RST; // see RQ13
      end
      else
      begin
         for (kf = 0; kf < 8; kf = kf + 1)
         begin
            if (!pin_sense_select[kf])
               edge_flag[kf] <= 1'b0;
            else if (pin_fall[kf])
               edge_flag[kf] <= 1'b1; // see RQ17
            else if (clr_req[kf])
               edge_flag[kf] <= 1'b0; // see RQ11 see RQ18
         end
      end
   end

   // arming: a completed read that returned 1 allows one clearing write
   // any flag write disarms every pin, so a later clear needs a fresh read
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         armed <= 8'h00;
      end
      else if (rd_flags)
      begin
         for (ka = 0; ka < 8; ka = ka + 1)
            armed[ka] <= prdata_o[7-ka]; // see RQ20
      end
      else if (wr_flags)
      begin
         armed <= 8'h00;
      end
   end

   // nmi edge detection on the chosen edge
   // a new edge choice applies from the cycle after its write
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         nmi_detect_o <= 1'b0;
      else if (nmi_edge_select)
         nmi_detect_o <= ~pin_prev[8] & sync_b[8]; // see RQ7
      else
         nmi_detect_o <= pin_prev[8] & ~sync_b[8];
   end

   // apb answer: data and error sampled at setup, ready in the access cycle
   // the slave never waits: one access cycle per transfer, unmapped words raise pslverr
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         prdata_o <= 32'h0000_0000;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end
      else
      begin
         pready_o <= setup;
         if (setup)
         begin
            pslverr_o <= ~mapped;
            if (!mapped || pwrite_i)
               prdata_o <= 32'h0000_0000;
            else if (idx <= `IPSC_IDX_PRIO_LAST)
               prdata_o <= {16'h0000, prio[idx[2:0]]};
            else if (idx == `IPSC_IDX_SENSE)
               prdata_o <= {16'h0000, sync_b[8], 6'h00, nmi_edge_select, sense_rev}; // see RQ5 see RQ6
            else
               prdata_o <= {24'h000000, shown_rev}; // see RQ6 see RQ10
         end
         else if (done)
         begin
            pslverr_o <= 1'b0;
         end
      end
   end

   // request vector in ranking order: pins first, then peripherals
   // row 36 is the second converter source, absent without the a-mask variant
   always @*
   begin
      req_all = {periph_req_i, shown};
      if (AMASK == 0)
         req_all[44] = 1'b0; // see RQ16
   end

   // highest level wins, ties keep the earlier source
   // strict compare: level 0 never wins and equal levels keep the higher-ranked source
   always @*
   begin
      best_lvl = 4'h0;
      best_vec = 8'h00;
      lvl = 4'h0;
      ent = 13'h0000;
      for (s = 0; s < NSRC; s = s + 1)
      begin
         if (s < 8)
            ent = {s[4:0], 8'h40 + s[7:0]};
         else
            ent = ipsc_src(s[5:0] - 6'd8); // see RQ14 see RQ3
         case (ent[9:8])
            2'd0: lvl = prio[ent[12:10]][15:12]; // see RQ1 see RQ2
            2'd1: lvl = prio[ent[12:10]][11:8];
            2'd2: lvl = prio[ent[12:10]][7:4];
            default: lvl = prio[ent[12:10]][3:0];
         endcase
         if (req_all[s] && (lvl > best_lvl))
         begin
            best_lvl = lvl; // see RQ15 see RQ1
            best_vec = ent[7:0];
         end
      end
   end

   // forward to the cpu only above its mask level
   // the pending output is the active-low copy of the cpu request
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         irq_req_o <= 1'b0;
         irq_vector_o <= 8'h00;
         irq_level_o <= 4'h0;
         request_pending_output_n_o <= 1'b1;
      end
      else
      begin
         irq_req_o <= (best_lvl > cpu_mask_level_i); // see RQ19
         request_pending_output_n_o <= ~(best_lvl > cpu_mask_level_i);
         irq_vector_o <= best_vec;
         irq_level_o <= best_lvl;
      end
   end

endmodule // ipsc_top

// ===== verif/ipsc_pins_model.sv
// far-side model: pulled-up request pins, nmi pin and cpu acceptance
`timescale 1ns/100ps
module ipsc_pins_model (
   // bench control
   input wire clk_i,
   input wire [7:0] low_req_i,
   input wire nmi_level_i,
   input wire accept_en_i,
   // controller request
   input wire irq_req_i,
   input wire [7:0] irq_vector_i,
   // pins and acceptance
   output reg [7:0] pins_n_o = 8'hff,
   output reg nmi_o = 1'b1,
   output reg [7:0] pin_accept_o = 8'h00
);
   // a released pin returns to its pull-up level
   always @(posedge clk_i)
   begin
      pins_n_o <= ~low_req_i;
      nmi_o <= nmi_level_i;
      pin_accept_o <= 8'h00;
      if (accept_en_i && irq_req_i && irq_vector_i[7:3] == 5'h08)
         pin_accept_o <= 8'h01 << irq_vector_i[2:0];
   end
endmodule // ipsc_pins_model

// ===== verif/ipsc_top_chk.sv
// assertion checker for the priority and sense controller
`timescale 1ns/100ps
module ipsc_top_chk (
   // clock, reset and apb
   input wire clk_i,
   input wire resetn_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] prdata_o,
   input wire pready_o,
   input wire pslverr_o,
   // request side
   input wire [3:0] cpu_mask_level_i,
   input wire irq_req_o,
   input wire [7:0] irq_vector_o,
   input wire [3:0] irq_level_o,
   input wire request_pending_output_n_o,
   input wire nmi_detect_o
);
   // one clock domain
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_rd(logic [11:0] a);
      pready_o && !pwrite_i && paddr_i == a;
   endsequence
   a_apb_answer: assert property (s_setup |=> pready_o ##1 !pready_o) else $error("apb answer");
   a_sense_rsvd: assert property (s_rd(12'h020) |-> prdata_o[14:9] == 6'h00) else $error("sense rsvd");
   a_flag_rsvd: assert property (s_rd(12'h024) |-> prdata_o[15:8] == 8'h00) else $error("flag rsvd");
   a_unmapped_err: assert property (pready_o && paddr_i[5:2] > 4'h9 |-> pslverr_o) else $error("unmapped");
   a_irq_gate: assert property (irq_req_o == (irq_level_o > $past(cpu_mask_level_i))) else $error("gate");
   a_pend_inverse: assert property (request_pending_output_n_o != irq_req_o) else $error("pending");
   a_vector_idle: assert property (irq_level_o == 4'h0 |-> irq_vector_o == 8'h00) else $error("idle");
   a_nmi_pulse: assert property ($rose(nmi_detect_o) |=> !nmi_detect_o) else $error("nmi pulse");
endmodule // ipsc_top_chk
bind ipsc_top ipsc_top_chk ipsc_top_chk_i (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .cpu_mask_level_i(cpu_mask_level_i), .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o),
   .irq_level_o(irq_level_o), .request_pending_output_n_o(request_pending_output_n_o), .nmi_detect_o(nmi_detect_o));

// ===== verif/tb.sv
// self-checking bench for the priority and sense controller
`timescale 1ns/100ps
module tb;
   logic clk_i = 1'b0, resetn_i = 1'b0, mrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata;
   logic [42:0] preq = 43'h0;
   logic [3:0] mask = 4'h0, lvl;
   logic [7:0] low = 8'h00, xd = 8'h00, pins_n, acc, vec;
   logic nmi_lvl = 1'b1, acc_en = 1'b0, nmi_pin, rdy, serr, irq, pend_n, nmi_det, lerr;
   logic [15:0] rd, v;
   int err_total = 0, n_checks = 0, cyc = 0, nmi_cnt = 0, c;
   logic [42:0] tm [8] = '{43'h7800_0000, 43'h7000_0000, 43'h200_0000_0000, 43'h300_0000_0000, 43'h2_0000,
      43'h400_0000_0000, 43'h10_0000_0000, 43'h18_0000_0000};
   logic [3:0] tr [8] = '{4'h5, 4'h5, 4'h7, 4'h7, 4'h4, 4'h7, 4'h6, 4'h6};
   logic [15:0] tv [8] = '{16'h00f0, 16'h00f0, 16'h6000, 16'h6000, 16'h0030, 16'h0900, 16'h7000, 16'h7000};
   logic [7:0] te [8] = '{8'h80, 8'h81, 8'h99, 8'h98, 8'h70, 8'h9c, 8'h89, 8'h88};
   logic [3:0] tl [8] = '{4'hf, 4'hf, 4'h6, 4'h6, 4'h3, 4'h9, 4'h7, 4'h7};
   always #12.5 clk_i = ~clk_i;
   ipsc_top #(.AMASK(1)) ipsc_top_i (.clk_i(clk_i), .resetn_i(resetn_i), .manual_reset_i(mrst), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata),
      .pready_o(rdy), .pslverr_o(serr), .nmi_pin_i(nmi_pin), .external_request_pins_n_i(pins_n),
      .periph_req_i(preq), .cpu_mask_level_i(mask), .pin_accept_i(acc), .xfer_done_i(xd), .irq_req_o(irq),
      .irq_vector_o(vec), .irq_level_o(lvl), .request_pending_output_n_o(pend_n), .nmi_detect_o(nmi_det));
   ipsc_pins_model ipsc_pins_model_i (.clk_i(clk_i), .low_req_i(low), .nmi_level_i(nmi_lvl), .accept_en_i(acc_en),
      .irq_req_i(irq), .irq_vector_i(vec), .pins_n_o(pins_n), .nmi_o(nmi_pin), .pin_accept_o(acc));
   // verdict and end of run
   task conclude;
      if (err_total == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task apb(input logic w, input logic [3:0] ix, input logic [15:0] d);
      @(posedge clk_i);
      psel <= 1'b1;
      pwr <= w;
      paddr <= {6'h00, ix, 2'h0};
      pwdata <= {16'h0000, d};
      @(posedge clk_i);
      pen <= 1'b1;
      do
         @(posedge clk_i);
      while (rdy !== 1'b1);
      rd = prdata[15:0];
      lerr = serr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task rc(input logic [3:0] ix, input logic [15:0] e);
      apb(1'b0, ix, 16'h0000);
      chk(rd, e);
   endtask
   task w(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   function logic [15:0] sense_exp(input logic nmi, input logic [15:0] wv);
      return {nmi, 6'h00, wv[8:0]};
   endfunction
   // cycle ceiling and nmi pulse count
   always @(posedge clk_i)
   begin
      cyc++;
      if (nmi_det === 1'b1)
         nmi_cnt++;
      if (cyc == 20000)
      begin
         err_total++;
         conclude;
      end
   end
   // main sequence
   initial
   begin
      void'($urandom(80091));
      w(8);
      resetn_i <= 1'b1;
      for (int i = 0; i < 10; i++)
         rc(i[3:0], i == 8 ? 16'h8000 : 16'h0000);
      rc(4'ha, 16'h0000);
      chk({15'h0000, lerr}, 16'h0001);
      for (int i = 0; i < 8; i++)
      begin
         v = 16'($urandom);
         apb(1'b1, i[3:0], v);
         rc(i[3:0], v);
      end
      apb(1'b1, 4'h8, 16'h00a5);
      @(posedge clk_i);
      mrst <= 1'b1;
      @(posedge clk_i);
      mrst <= 1'b0;
      for (int i = 0; i < 8; i++)
         rc(i[3:0], 16'h0000);
      rc(4'h8, sense_exp(1'b1, 16'h00a5));
      apb(1'b1, 4'h8, 16'h81ff);
      rc(4'h8, sense_exp(1'b1, 16'h81ff));
      c = nmi_cnt;
      nmi_lvl <= 1'b0;
      w(6);
      rc(4'h8, sense_exp(1'b0, 16'h81ff));
      nmi_lvl <= 1'b1;
      w(6);
      chk(16'(nmi_cnt - c), 16'h0001);
      apb(1'b1, 4'h8, 16'h0000);
      nmi_lvl <= 1'b0;
      w(6);
      chk(16'(nmi_cnt - c), 16'h0002);
      nmi_lvl <= 1'b1;
      low <= 8'h01;
      w(5);
      rc(4'h9, 16'h0080);
      low <= 8'h00;
      w(5);
      rc(4'h9, 16'h0000);
      apb(1'b1, 4'h8, 16'h0010);
      low <= 8'h08;
      w(2);
      low <= 8'h00;
      w(5);
      apb(1'b1, 4'h9, 16'h0000);
      apb(1'b1, 4'h9, 16'h00ff);
      rc(4'h9, 16'h0010);
      apb(1'b1, 4'h9, 16'h0000);
      rc(4'h9, 16'h0000);
      apb(1'b1, 4'h0, 16'h0002);
      low <= 8'h08;
      w(2);
      low <= 8'h00;
      w(6);
      chk({vec, lvl, 2'h0, pend_n, irq}, 16'h4321);
      acc_en <= 1'b1;
      w(6);
      rc(4'h9, 16'h0000);
      acc_en <= 1'b0;
      low <= 8'h08;
      w(2);
      low <= 8'h00;
      w(6);
      rc(4'h9, 16'h0010);
      xd <= 8'h08;
      @(posedge clk_i);
      xd <= 8'h00;
      w(2);
      rc(4'h9, 16'h0000);
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b1, tr[i], tv[i]);
         preq <= tm[i];
         mask <= tl[i] - 4'h1;
         w(4);
         chk({vec, lvl, 2'h0, pend_n, irq}, {te[i], tl[i], 4'h1});
         mask <= tl[i];
         w(3);
         chk({14'h0000, pend_n, irq}, 16'h0002);
         preq <= 43'h0;
      end
      conclude;
   end
endmodule // tb
